/* src/fskrx_ctrl.v */
// fsk receive mode select and energy / 2100 hz detector with apb registers
//
// Local design decisions: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "fskrx_regs.vh"
module fskrx_ctrl (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [7:0] rx_level,
  input wire rx_sign,
  input wire rx_fsk_bit,
  output reg osc_en,
  output reg [1:0] band_sel,
  output reg eq_en,
  output reg demod_en,
  output reg uart_rx_bit,
  output reg energy_det,
  output reg irq
);
  reg [7:0] mode_r;
  reg [7:0] tone_r;
  reg [1:0] stat_r;
  reg [1:0] mask_r;
  reg [7:0] lvl_on_r;
  reg [7:0] lvl_off_r;
  reg standby_r;
  reg [7:0] lvl_s1_r;
  reg [7:0] lvl_s2_r;
  reg [2:0] sgn_s_r;
  reg [1:0] bit_s_r;
  reg [15:0] per_cnt_r;
  reg tone_ok_r;
  reg [15:0] qual_cnt_r;
  reg det_r;
  reg [31:0] rd_nxt;
  reg ready_nxt;
  reg err_nxt;
  reg [1:0] stat_nxt;
  reg [15:0] qual_nxt;
  reg det_nxt;
  reg [15:0] per_nxt;
  reg tone_ok_nxt;
  wire stat_wr;
  wire demod_on;
  wire [1:0] pend;
  wire wr_en;
  wire rd_en;
  wire hit;
  wire tone_mode;
  wire above;
  wire below;
  wire sgn_rise;
  wire det_set;
  wire det_clr;

  function [15:0] cyc16;
    input integer v;
    begin
      cyc16 = v[15:0];
    end
  endfunction

  // demodulator gate, shared by its enable and the uart bit
  function demod_gate;
    input stby;
    input [7:0] md;
    begin
      demod_gate = ~stby & md[`FSKRX_MODE_DEMOD] & md[`FSKRX_MODE_BAND_HI];
    end
  endfunction

  // write strobe for one offset, taken at the access edge only
  function wr_hit;
    input we;
    input rdy;
    input [11:0] a;
    input [11:0] off;
    begin
      wr_hit = we & rdy & (a == off);
    end
  endfunction

  // both band bits set: the 1200 bps band
  function band_high;
    input [7:0] md;
    begin
      band_high = md[`FSKRX_MODE_BAND_HI] & md[`FSKRX_MODE_BAND_LO];
    end
  endfunction

  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & ~pwrite;
  // unmapped offsets answer with an error and change nothing
  assign hit = (paddr == `FSKRX_OFF_MODE) | (paddr == `FSKRX_OFF_TONE) |
               (paddr == `FSKRX_OFF_STAT) | (paddr == `FSKRX_OFF_MASK) |
               (paddr == `FSKRX_OFF_LVL) | (paddr == `FSKRX_OFF_CTRL);
  assign stat_wr = wr_hit(wr_en, pready, paddr, `FSKRX_OFF_STAT);
  assign demod_on = demod_gate(standby_r, mode_r);
  assign pend = stat_r & mask_r;

  // detection mode: tone bit 0 with both band bits set selects 2100 hz
  assign tone_mode = tone_r[`FSKRX_TONE_2100] & band_high(mode_r);
  // amplitude hysteresis: distinct on and off thresholds
  assign above = (lvl_s2_r >= lvl_on_r);
  assign below = (lvl_s2_r < lvl_off_r);
  // the second and third sync stages feed the edge detector
  assign sgn_rise = sgn_s_r[1] & ~sgn_s_r[2];

  always @* begin
    rd_nxt = 32'h0000_0000;
    case (paddr)
      `FSKRX_OFF_MODE: rd_nxt = {24'h00_0000, mode_r};
      `FSKRX_OFF_TONE: rd_nxt = {24'h00_0000, tone_r};
      `FSKRX_OFF_STAT: rd_nxt = {24'h00_0000, 3'h0, det_r, 2'h0, stat_r};
      `FSKRX_OFF_MASK: rd_nxt = {30'h0000_0000, mask_r};
      `FSKRX_OFF_LVL: rd_nxt = {16'h0000, lvl_off_r, lvl_on_r};
      `FSKRX_OFF_CTRL: rd_nxt = {31'h0000_0000, standby_r};
      default: rd_nxt = 32'h0000_0000;
    endcase
  end

  // prdata is loaded in setup so it stands still through the access cycle
  always @* begin
    ready_nxt = psel & ~penable;
    err_nxt = psel & ~penable & ~hit;
  end

  // apb slave: zero wait, error on unmapped address
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= ready_nxt;
      pslverr <= err_nxt;
      if (rd_en & ~penable)
        prdata <= rd_nxt;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r <= `FSKRX_MODE_RST;
      tone_r <= `FSKRX_TONE_RST;
      mask_r <= `FSKRX_MASK_RST;
      lvl_on_r <= `FSKRX_LVL_ON_RST;
      lvl_off_r <= `FSKRX_LVL_OFF_RST;
      standby_r <= `FSKRX_CTRL_RST;
    end else begin
      if (wr_hit(wr_en, pready, paddr, `FSKRX_OFF_MODE))
        mode_r <= pwdata[7:0];
      if (wr_hit(wr_en, pready, paddr, `FSKRX_OFF_TONE))
        tone_r <= pwdata[7:0];
      if (wr_hit(wr_en, pready, paddr, `FSKRX_OFF_MASK))
        mask_r <= pwdata[1:0];
      if (wr_hit(wr_en, pready, paddr, `FSKRX_OFF_LVL)) begin
        lvl_on_r <= pwdata[7:0];
        lvl_off_r <= pwdata[15:8];
      end
      if (wr_hit(wr_en, pready, paddr, `FSKRX_OFF_CTRL))
        standby_r <= pwdata[0];
    end
  end

  // analogue-side inputs are asynchronous: two flops before use
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lvl_s1_r <= 8'h00;
      lvl_s2_r <= 8'h00;
      sgn_s_r <= 3'h0;
      bit_s_r <= 2'h0;
    end else begin
      lvl_s1_r <= rx_level;
      lvl_s2_r <= lvl_s1_r;
      sgn_s_r <= {sgn_s_r[1:0], rx_sign};
      bit_s_r <= {bit_s_r[0], rx_fsk_bit};
    end
  end

  // 2100 hz check: period between sign rises measured in pclk cycles
  // the period counter saturates so a dead line cannot wrap into the window
  always @* begin
    per_nxt = per_cnt_r;
    tone_ok_nxt = tone_ok_r;
    if (standby_r) begin
      per_nxt = 16'h0000;
      tone_ok_nxt = 1'b0;
    end else if (sgn_rise) begin
      per_nxt = 16'h0000;
      tone_ok_nxt = (per_cnt_r >= `FSKRX_F2100_LO) & (per_cnt_r <= `FSKRX_F2100_HI);
    end else if (per_cnt_r != 16'hffff) begin
      per_nxt = per_cnt_r + 16'h0001;
      if (per_cnt_r > `FSKRX_F2100_HI)
        tone_ok_nxt = 1'b0;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      per_cnt_r <= 16'h0000;
      tone_ok_r <= 1'b0;
    end else begin
      per_cnt_r <= per_nxt;
      tone_ok_r <= tone_ok_nxt;
    end
  end

  // time hysteresis: qualifying counter for set and release
  assign det_set = ~det_r & above & (~tone_mode | tone_ok_r);
  assign det_clr = det_r & (below | (tone_mode & ~tone_ok_r));

  // standby drops the flag so no stale detection survives a clock stop
  always @* begin
    qual_nxt = 16'h0000;
    det_nxt = det_r;
    if (standby_r) begin
      det_nxt = 1'b0;
    end else if (det_set) begin
      if (qual_cnt_r >= cyc16(`FSKRX_TON_CYC - 1))
        det_nxt = 1'b1;
      else
        qual_nxt = qual_cnt_r + 16'h0001;
    end else if (det_clr) begin
      if (qual_cnt_r >= cyc16(`FSKRX_TOFF_CYC - 1))
        det_nxt = 1'b0;
      else
        qual_nxt = qual_cnt_r + 16'h0001;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      qual_cnt_r <= 16'h0000;
      det_r <= 1'b0;
    end else begin
      qual_cnt_r <= qual_nxt;
      det_r <= det_nxt;
    end
  end

  // sticky edge flags; a new edge wins over a write-one clear
  always @* begin
    stat_nxt = stat_r;
    if (stat_wr)
      stat_nxt = stat_r & ~pwdata[1:0];
    if (det_r & ~energy_det)
      stat_nxt[`FSKRX_IRQ_RISE] = 1'b1;
    if (energy_det & ~det_r)
      stat_nxt[`FSKRX_IRQ_FALL] = 1'b1;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      stat_r <= 2'h0;
    else
      stat_r <= stat_nxt;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_en <= 1'b0;
      band_sel <= `FSKRX_BAND_CP;
      eq_en <= 1'b0;
      demod_en <= 1'b0;
      uart_rx_bit <= 1'b1;
    end else begin
      osc_en <= ~standby_r;
      band_sel <= {mode_r[`FSKRX_MODE_BAND_HI], mode_r[`FSKRX_MODE_BAND_LO]};
      eq_en <= mode_r[`FSKRX_MODE_EQ] & band_high(mode_r);
      demod_en <= demod_on;
      // idle mark while the demodulator is off
      uart_rx_bit <= demod_on ? bit_s_r[1] : 1'b1;
    end
  end

  // flag outputs; irq trails the status bits by one cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      energy_det <= 1'b0;
      irq <= 1'b0;
    end else begin
      energy_det <= det_r;
      irq <= |pend;
    end
  end
endmodule // fskrx_ctrl

/* src/fskrx_regs.vh */
// register map, field positions, reset values and timing counts of the fsk receive control block
`ifndef FSKRX_REGS_VH
`define FSKRX_REGS_VH
`define FSKRX_OFF_MODE 12'h000
`define FSKRX_OFF_TONE 12'h004
`define FSKRX_OFF_STAT 12'h008
`define FSKRX_OFF_MASK 12'h00c
`define FSKRX_OFF_LVL 12'h010
`define FSKRX_OFF_CTRL 12'h014
`define FSKRX_MODE_RST 8'h00
`define FSKRX_TONE_RST 8'h00
`define FSKRX_MASK_RST 2'h0
`define FSKRX_LVL_ON_RST 8'h40
`define FSKRX_LVL_OFF_RST 8'h30
`define FSKRX_CTRL_RST 1'h1
`define FSKRX_MODE_DEMOD 1
`define FSKRX_MODE_BAND_LO 4
`define FSKRX_MODE_BAND_HI 5
`define FSKRX_MODE_EQ 6
`define FSKRX_TONE_2100 0
`define FSKRX_STAT_EDET 4
`define FSKRX_IRQ_RISE 0
`define FSKRX_IRQ_FALL 1
`define FSKRX_REF_KHZ 3580
`define FSKRX_PCLK_KHZ 20000
`define FSKRX_TON_US 40
`define FSKRX_TOFF_US 20
`define FSKRX_TON_CYC ((`FSKRX_TON_US * `FSKRX_PCLK_KHZ + 999) / 1000)
`define FSKRX_TOFF_CYC ((`FSKRX_TOFF_US * `FSKRX_PCLK_KHZ + 999) / 1000)
`define FSKRX_F2100_LO 16'd840
`define FSKRX_F2100_HI 16'd1070
`define FSKRX_BAND_CP 2'h0
`define FSKRX_BAND_LOW 2'h2
`define FSKRX_BAND_HIGH 2'h3
`endif

/* testbench/fskrx_chk.sv */
// assertion checker for the fsk receive control block
`timescale 1ns/1ps
module fskrx_chk (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pready,
  input wire [7:0] rx_level,
  input wire osc_en,
  input wire [1:0] band_sel,
  input wire eq_en,
  input wire demod_en,
  input wire uart_rx_bit,
  input wire energy_det
);
  reg [10:0] hi_r;
  reg [10:0] lo_r;
  // run lengths against the reset thresholds; the bench never rewrites them
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hi_r <= 11'h0;
      lo_r <= 11'h0;
    end else begin
      hi_r <= (rx_level >= 8'h40) ? hi_r + {10'h0, ~&hi_r} : 11'h0;
      lo_r <= (rx_level < 8'h30) ? lo_r + {10'h0, ~&lo_r} : 11'h0;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_eq_band: assert property (eq_en |-> band_sel == 2'h3) else $error("eq outside 1200");
  a_demod_band: assert property (demod_en |-> band_sel[1] && osc_en)
    else $error("demod enabled wrongly");
  a_uart_idle: assert property (!demod_en ##1 !demod_en |-> uart_rx_bit)
    else $error("uart bit not idle");
  a_stby_det: assert property (!osc_en ##1 !osc_en |=> !energy_det)
    else $error("flag set in standby");
  a_det_set: assert property ($rose(energy_det) |-> hi_r >= 11'd800)
    else $error("flag set too early");
  a_det_clear: assert property ($fell(energy_det) |-> lo_r >= 11'd400 || !osc_en)
    else $error("flag cleared too early");
  a_det_hold: assert property ($rose(energy_det) && osc_en |=> energy_det [*8])
    else $error("flag chatters");
  a_apb_slot: assert property (psel && !penable |=> pready) else $error("no ready");
  c_rise: cover property ($rose(energy_det));
  c_fall: cover property ($fell(energy_det));
  c_demod: cover property (demod_en && eq_en);
endmodule // fskrx_chk
bind fskrx_ctrl fskrx_chk u_chk (.*);

/* testbench/fskrx_ctrl_tb.sv */
// self-checking bench for the fsk receive control block
`timescale 1ns/1ps
`include "fskrx_regs.vh"
`define CHK(n, e, g) begin n_tests = n_tests + 1; if ((g) !== (e)) begin \
  fails = fails + 1; $display("MISMATCH %s exp %h got %h", n, e, g); end end
module fskrx_ctrl_tb;
  reg pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  reg [11:0] paddr = 12'h0;
  reg [31:0] pwdata = 32'h0, rd, rnd;
  reg [7:0] lvl = 8'h0, m;
  reg [10:0] half = 11'h0;
  reg fbit = 1'h1, serr;
  integer fails = 0, n_tests = 0, seed = 20030, i;
  wire [31:0] prdata;
  wire [7:0] rx_level;
  wire [1:0] band_sel;
  wire pready, pslverr, rx_sign, rx_fsk_bit, osc_en, eq_en, demod_en, uart_rx_bit;
  wire energy_det, irq;
  fskrx_ctrl dut (.*);
  fskrx_line u_line (.*);
  always #25 pclk = ~pclk;
  task apb(input w, input [11:0] a, input [31:0] d);
    integer k;
    begin
      @(posedge pclk);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      // pready and prdata are read as sampled at the edge, before its own updates
      @(posedge pclk);
      for (k = 0; k < 16 && pready !== 1'h1; k = k + 1) @(posedge pclk);
      if (k == 16) fails = fails + 1;
      rd = prdata;
      serr = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
    end
  endtask
  task nw(input integer n);
    repeat (n) @(negedge pclk);
  endtask
  task print_verdict;
    begin
      $display("checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
    end
  endtask
  function [3:0] ex(input [7:0] md);
    ex = {md[5:4], md[6] & md[5] & md[4], md[1] & md[5]};
  endfunction
  initial begin
    #2000000;
    fails = fails + 1;
    print_verdict;
  end
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'h1;
    // standby stays set from reset while the reference is not yet trusted
    apb(1'h0, `FSKRX_OFF_CTRL, 32'h0);
    `CHK("ctrl", 32'h1, rd)
    `CHK("osc", 1'h0, osc_en)
    apb(1'h0, `FSKRX_OFF_LVL, 32'h0);
    `CHK("lvl", 32'h3040, rd)
    apb(1'h0, 12'h018, 32'h0);
    `CHK("slverr", 1'h1, serr)
    apb(1'h1, `FSKRX_OFF_CTRL, 32'h0);
    nw(2);
    `CHK("osc", 1'h1, osc_en)
    $display("reset test done");
    for (i = 0; i < 12; i = i + 1) begin
      rnd = $random(seed);
      m = (i == 0) ? 8'h72 : (i == 1) ? 8'h22 : rnd[7:0] & 8'h72;
      apb(1'h1, `FSKRX_OFF_MODE, {24'h0, m});
      fbit <= rnd[8];
      nw(6);
      `CHK("mode", ex(m), {band_sel, eq_en, demod_en})
      `CHK("uart", (m[1] & m[5]) ? rnd[8] : 1'h1, uart_rx_bit)
    end
    $display("mode test done");
    apb(1'h1, `FSKRX_OFF_MODE, 32'h0);
    lvl <= 8'h50;
    nw(700);
    `CHK("det", 1'h0, energy_det)
    nw(150);
    `CHK("det", 1'h1, energy_det)
    `CHK("irq", 1'h0, irq)
    apb(1'h0, `FSKRX_OFF_STAT, 32'h0);
    `CHK("stat", 5'h11, rd[4:0])
    apb(1'h1, `FSKRX_OFF_MASK, 32'h1);
    nw(2);
    `CHK("irq", 1'h1, irq)
    apb(1'h1, `FSKRX_OFF_STAT, 32'h1);
    nw(2);
    `CHK("irq", 1'h0, irq)
    @(posedge pclk);
    lvl <= 8'h38;
    nw(500);
    `CHK("det", 1'h1, energy_det)
    @(posedge pclk);
    lvl <= 8'h10;
    nw(300);
    `CHK("det", 1'h1, energy_det)
    nw(150);
    `CHK("det", 1'h0, energy_det)
    $display("level test done");
    apb(1'h1, `FSKRX_OFF_TONE, 32'h1);
    apb(1'h1, `FSKRX_OFF_MODE, 32'h30);
    half <= 11'd300;
    lvl <= 8'h50;
    nw(3000);
    `CHK("tone", 1'h0, energy_det)
    @(posedge pclk);
    half <= 11'd480;
    nw(4000);
    `CHK("tone", 1'h1, energy_det)
    apb(1'h1, `FSKRX_OFF_CTRL, 32'h1);
    nw(3);
    `CHK("osc", 1'h0, osc_en)
    `CHK("det", 1'h0, energy_det)
    $display("tone test done");
    print_verdict;
  end
endmodule // fskrx_ctrl_tb

/* testbench/fskrx_line.sv */
// line model: filtered level, zero-cross sign and raw demod bit
`timescale 1ns/1ps
module fskrx_line (
  input wire pclk,
  input wire [7:0] lvl,
  input wire [10:0] half,
  input wire fbit,
  output reg [7:0] rx_level,
  output reg rx_sign,
  output reg rx_fsk_bit
);
  reg [10:0] cnt;
  initial begin
    cnt = 11'h0;
    rx_sign = 1'h0;
  end
  // sign stands still when no tone is applied
  always @(posedge pclk) begin
    rx_level <= lvl;
    rx_fsk_bit <= fbit;
    cnt <= (cnt >= half) ? 11'h0 : cnt + 11'h1;
    if (half != 11'h0 && cnt >= half)
      rx_sign <= ~rx_sign;
  end
endmodule // fskrx_line
